/* design/gpr_pkg.sv */
// package: register map, field positions and types of the gigabit phy regs
package gpr_pkg;
   // register indices (byte address is four times the index)
   localparam logic [7:0] GPR_IDX_GCTRL = 8'h09;
   localparam logic [7:0] GPR_IDX_GSTAT = 8'h0a;
   localparam logic [7:0] GPR_IDX_FCAP = 8'h0f;
   localparam logic [7:0] GPR_IDX_FEXT = 8'h10;
   localparam logic [7:0] GPR_IDX_GEXT = 8'h11;
   localparam logic [7:0] GPR_IDX_IRQ_STAT = 8'h20;
   localparam logic [7:0] GPR_IDX_IRQ_MASK = 8'h21;
   // gigabit control fields
   localparam int GPR_TM_LSB = 13;
   localparam int GPR_MS_EN_BIT = 12;
   localparam int GPR_MS_VAL_BIT = 11;
   localparam int GPR_PORT_BIT = 10;
   localparam int GPR_FDX_BIT = 9;
   localparam int GPR_HDX_BIT = 8;
   localparam logic [15:0] GPR_GCTRL_RST = 16'h0400;
   localparam logic [15:0] GPR_GCTRL_WMASK = 16'hffff;
   // fixed capability value
   localparam logic [15:0] GPR_FCAP_VAL = 16'h3000;
   // test modes
   typedef enum logic [2:0] {
      GPR_TM_NORMAL = 3'h0,
      GPR_TM_WAVEFORM = 3'h1,
      GPR_TM_JIT_MASTER = 3'h2,
      GPR_TM_JIT_SLAVE = 3'h3,
      GPR_TM_DISTORT = 3'h4
   } gpr_tm_e;
   // bus slave states
   typedef enum logic [1:0] {
      GPR_BUS_IDLE = 2'b00,
      GPR_BUS_ACK = 2'b01
   } gpr_bus_e;
   // per-speed event inputs, one pulse per cycle of occurrence
   typedef struct packed {
      logic lock_err;
      logic disconnect;
      logic rx_err;
      logic tx_err;
      logic ssd_err;
      logic esd_err;
      logic ext_err;
   } gpr_evt_s;
   // per-speed level status
   typedef struct packed {
      logic descr_lock;
      logic link_up;
   } gpr_lvl_s;
   localparam int GPR_NEVT = 7;
   localparam logic [7:0] GPR_IDLE_MAX = 8'hff;
   // interrupt status bits
   localparam int GPR_IRQ_MSFAULT = 0;
   localparam int GPR_IRQ_FEXT = 1;
   localparam int GPR_IRQ_GEXT = 2;
   localparam int GPR_IRQ_IDLE = 3;
   localparam int GPR_NIRQ = 4;
endpackage

/* design/gpr_regs.sv */
// gigabit phy management registers behind a classic wishbone slave
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/10ps
// Summary of operation
// - test mode field: zero normal, one to four select the four tx tests
// - manual master/slave enable picks value bit; otherwise ignored; reset zero
// - port type bit: one multi-port, zero single; resets to one
// - gigabit duplex advertise bits writable, reset from config pins
// - master/slave fault latches high until status read; reset zero
// - resolution bit one for master, zero for slave; resets to one
// - local and remote receiver ok bits, zero after reset
// - partner gigabit full and half duplex ability bits, reset zero
// - capability register: x abilities zero, t abilities one, low bits zero
// - fast ethernet extension: descrambler lock and link bits, reset zero
// - fast ethernet extension: six self-clearing error flags
// - gigabit extension: descrambler lock and link bits, reset zero
// - gigabit extension: six self-clearing flags plus carrier extension
module gpr_regs
   import gpr_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // configuration pins for advertised gigabit abilities
   input wire logic config_pin_default_fdx_i,
   input wire logic config_pin_default_hdx_i,
   // negotiation and receiver status from datapath
   input wire logic ms_fault_i,
   input wire logic ms_master_i,
   input wire logic local_rx_ok_i,
   input wire logic remote_rx_ok_i,
   input wire logic lp_fdx_i,
   input wire logic lp_hdx_i,
   input wire logic idle_err_i,
   input wire gpr_lvl_s fe_lvl_i,
   input wire gpr_evt_s fe_evt_i,
   input wire gpr_lvl_s ge_lvl_i,
   input wire gpr_evt_s ge_evt_i,
   // control outputs to datapath
   output logic [2:0] test_mode_o,
   output logic ms_manual_o,
   output logic ms_force_master_o,
   output logic multi_port_o,
   output logic adv_fdx_o,
   output logic adv_hdx_o,
   // interrupt
   output logic irq_o
);

   logic [15:0] gctrl_q;
   logic ms_fault_q;
   logic ms_res_q;
   logic [3:0] gstat_lvl_q;
   logic [7:0] idle_cnt_q;
   logic [GPR_NEVT-1:0] fe_flag_q;
   logic [GPR_NEVT-1:0] ge_flag_q;
   gpr_lvl_s fe_lvl_q;
   gpr_lvl_s ge_lvl_q;
   logic [GPR_NIRQ-1:0] irq_stat_q;
   logic [GPR_NIRQ-1:0] irq_mask_q;
   logic [GPR_NIRQ-1:0] irq_evt;
   gpr_bus_e bus_q;
   logic strap_pend_q;
   logic req;
   logic rd_stb;
   logic wr_stb;
   logic [15:0] rd_data;

   // register selected by index; unmapped reads return zero
   function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
      hit = (a == idx);
   endfunction

   assign req = cyc_i && stb_i && (bus_q == GPR_BUS_IDLE);
   assign rd_stb = req && !we_i;
   assign wr_stb = req && we_i;

   // single-wait-state answer, ack dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_q <= GPR_BUS_IDLE;
         ack_o <= 1'b0;
      end else begin
         case (bus_q)
            GPR_BUS_IDLE: begin
               ack_o <= req;
               if (req) begin
                  bus_q <= GPR_BUS_ACK;
               end
            end
            GPR_BUS_ACK: begin
               ack_o <= 1'b0;
               bus_q <= GPR_BUS_IDLE;
            end
            default: begin
               ack_o <= 1'b0;
               bus_q <= GPR_BUS_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      rd_data = 16'h0000;
      if (hit(adr_i, GPR_IDX_GCTRL)) begin
         rd_data = gctrl_q;
      end else if (hit(adr_i, GPR_IDX_GSTAT)) begin
         rd_data = {ms_fault_q, ms_res_q, gstat_lvl_q, 2'b00, idle_cnt_q};
      end else if (hit(adr_i, GPR_IDX_FCAP)) begin
         rd_data = GPR_FCAP_VAL;
      end else if (hit(adr_i, GPR_IDX_FEXT)) begin
         rd_data = {fe_lvl_q.descr_lock, fe_flag_q[6:5], fe_lvl_q.link_up,
                    fe_flag_q[4:1], 8'h00};
      end else if (hit(adr_i, GPR_IDX_GEXT)) begin
         rd_data = {ge_lvl_q.descr_lock, ge_flag_q[6:5], ge_lvl_q.link_up,
                    ge_flag_q[4:0], 7'h00};
      end else if (hit(adr_i, GPR_IDX_IRQ_STAT)) begin
         rd_data = {12'h000, irq_stat_q};
      end else if (hit(adr_i, GPR_IDX_IRQ_MASK)) begin
         rd_data = {12'h000, irq_mask_q};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (rd_stb) begin
         dat_o <= {16'h0000, rd_data};
      end
   end

   // control register; the duplex straps are taken one cycle after reset
   // release since an async-style capture of a pin at reset is not allowed
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gctrl_q <= GPR_GCTRL_RST;
         strap_pend_q <= 1'b1;
      end else begin
         strap_pend_q <= 1'b0;
         if (strap_pend_q) begin
            gctrl_q[GPR_FDX_BIT] <= config_pin_default_fdx_i;
            gctrl_q[GPR_HDX_BIT] <= config_pin_default_hdx_i;
         end
         if (wr_stb && hit(adr_i, GPR_IDX_GCTRL)) begin
            if (sel_i[0]) begin
               gctrl_q[7:0] <= dat_i[7:0] & GPR_GCTRL_WMASK[7:0];
            end
            if (sel_i[1]) begin
               gctrl_q[15:8] <= dat_i[15:8] & GPR_GCTRL_WMASK[15:8];
            end
         end
      end
   end

   // test codes above four are undefined; software keeps them out
   // and disables media sensing first
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         test_mode_o <= GPR_TM_NORMAL;
         ms_manual_o <= 1'b0;
         ms_force_master_o <= 1'b0;
         multi_port_o <= 1'b1;
         adv_fdx_o <= 1'b0;
         adv_hdx_o <= 1'b0;
      end else begin
         test_mode_o <= gctrl_q[GPR_TM_LSB +: 3];
         ms_manual_o <= gctrl_q[GPR_MS_EN_BIT];
         ms_force_master_o <= gctrl_q[GPR_MS_EN_BIT] &
                              gctrl_q[GPR_MS_VAL_BIT];
         multi_port_o <= gctrl_q[GPR_PORT_BIT];
         adv_fdx_o <= gctrl_q[GPR_FDX_BIT];
         adv_hdx_o <= gctrl_q[GPR_HDX_BIT];
      end
   end

   // gigabit status: fault latch, resolution, receivers, partner ability
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ms_fault_q <= 1'b0;
         ms_res_q <= 1'b1;
         gstat_lvl_q <= 4'h0;
      end else begin
         if (ms_fault_i) begin
            ms_fault_q <= 1'b1;
         end else if (rd_stb && hit(adr_i, GPR_IDX_GSTAT)) begin
            ms_fault_q <= 1'b0;
         end
         ms_res_q <= ms_master_i;
         gstat_lvl_q <= {local_rx_ok_i, remote_rx_ok_i,
                         lp_fdx_i, lp_hdx_i};
      end
   end

   // idle errors saturate; an error in the reading cycle restarts at one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idle_cnt_q <= 8'h00;
      end else if (rd_stb && hit(adr_i, GPR_IDX_GSTAT)) begin
         idle_cnt_q <= {7'h00, idle_err_i};
      end else if (idle_err_i && idle_cnt_q != GPR_IDLE_MAX) begin
         idle_cnt_q <= idle_cnt_q + 8'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fe_lvl_q <= '0;
         ge_lvl_q <= '0;
      end else begin
         fe_lvl_q <= fe_lvl_i;
         ge_lvl_q <= ge_lvl_i;
      end
   end

   // sticky error flags; fast ethernet has no carrier extension flag
   genvar gi;
   generate
      for (gi = 0; gi < GPR_NEVT; gi++) begin : g_flag
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               fe_flag_q[gi] <= 1'b0;
               ge_flag_q[gi] <= 1'b0;
            end else begin
               if (gi != 0 && fe_evt_i[gi]) begin
                  fe_flag_q[gi] <= 1'b1;
               end else if (rd_stb && hit(adr_i, GPR_IDX_FEXT)) begin
                  fe_flag_q[gi] <= 1'b0;
               end
               if (ge_evt_i[gi]) begin
                  ge_flag_q[gi] <= 1'b1;
               end else if (rd_stb && hit(adr_i, GPR_IDX_GEXT)) begin
                  ge_flag_q[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // interrupt: sticky status cleared by read, mask gates the level output
   assign irq_evt[GPR_IRQ_MSFAULT] = ms_fault_i;
   assign irq_evt[GPR_IRQ_FEXT] = |fe_evt_i[GPR_NEVT-1:1];
   assign irq_evt[GPR_IRQ_GEXT] = |ge_evt_i;
   assign irq_evt[GPR_IRQ_IDLE] = idle_err_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q <= '0;
         irq_mask_q <= '0;
         irq_o <= 1'b0;
      end else begin
         if (rd_stb && hit(adr_i, GPR_IDX_IRQ_STAT)) begin
            irq_stat_q <= irq_evt;
         end else begin
            irq_stat_q <= irq_stat_q | irq_evt;
         end
         if (wr_stb && sel_i[0] && hit(adr_i, GPR_IDX_IRQ_MASK)) begin
            irq_mask_q <= dat_i[GPR_NIRQ-1:0];
         end
         irq_o <= |(irq_stat_q & irq_mask_q);
      end
   end

   // checks
   fault_hold_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ms_fault_i |=> ms_fault_q)
      else $error("fault latch lost");

   fault_clear_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (rd_stb && hit(adr_i, GPR_IDX_GSTAT) && !ms_fault_i) |=> !ms_fault_q)
      else $error("fault not cleared by read");

   force_master_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ms_force_master_o |-> ms_manual_o)
      else $error("master forced without manual enable");

   idle_sat_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (idle_cnt_q == GPR_IDLE_MAX && idle_err_i && !rd_stb)
      |=> idle_cnt_q == GPR_IDLE_MAX)
      else $error("idle counter wrapped");

   idle_inc_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (idle_err_i && !rd_stb && idle_cnt_q != GPR_IDLE_MAX)
      |=> idle_cnt_q == $past(idle_cnt_q) + 8'h01)
      else $error("idle counter missed an error");

   ge_flag_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ge_evt_i.ext_err |=> ge_flag_q[0])
      else $error("carrier extension flag lost");

   fe_flag_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      fe_evt_i.lock_err |=> fe_flag_q[6])
      else $error("fast lock error flag lost");

   test_mode_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> test_mode_o == $past(gctrl_q[15:13]))
      else $error("test mode output stale");

   ack_pulse_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("ack held two cycles");

   ack_answer_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      req |=> ack_o)
      else $error("request not acknowledged");

   ms_res_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> ms_res_q == $past(ms_master_i))
      else $error("resolution bit stale");

   rx_status_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> gstat_lvl_q[3] == $past(local_rx_ok_i) &&
               gstat_lvl_q[2] == $past(remote_rx_ok_i))
      else $error("receiver status stale");

   lp_ability_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> gstat_lvl_q[1] == $past(lp_fdx_i) &&
               gstat_lvl_q[0] == $past(lp_hdx_i))
      else $error("partner ability stale");

   fcap_read_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (rd_stb && hit(adr_i, GPR_IDX_FCAP)) |=> dat_o == 32'h0000_3000)
      else $error("capability value wrong");

   fe_level_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> fe_lvl_q == $past(fe_lvl_i))
      else $error("fast level status stale");

   fe_noext_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !fe_flag_q[0])
      else $error("fast carrier extension flag set");

   ge_level_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> ge_lvl_q == $past(ge_lvl_i))
      else $error("gigabit level status stale");

   fe_clear_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (rd_stb && hit(adr_i, GPR_IDX_FEXT) && fe_evt_i == '0)
      |=> fe_flag_q == '0)
      else $error("fast flags not cleared by read");

   ge_clear_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (rd_stb && hit(adr_i, GPR_IDX_GEXT) && ge_evt_i == '0)
      |=> ge_flag_q == '0)
      else $error("gigabit flags not cleared by read");

   idle_clear_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (rd_stb && hit(adr_i, GPR_IDX_GSTAT) && !idle_err_i)
      |=> idle_cnt_q == 8'h00)
      else $error("idle counter not cleared by read");

   port_type_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> multi_port_o == $past(gctrl_q[GPR_PORT_BIT]))
      else $error("port type output stale");

   manual_ms_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> ms_manual_o == $past(gctrl_q[GPR_MS_EN_BIT]))
      else $error("manual enable output stale");

   strap_load_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (strap_pend_q && !wr_stb)
      |=> gctrl_q[GPR_FDX_BIT] == $past(config_pin_default_fdx_i) &&
          gctrl_q[GPR_HDX_BIT] == $past(config_pin_default_hdx_i))
      else $error("duplex straps not loaded");

   irq_level_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (|(irq_stat_q & irq_mask_q)) |=> irq_o)
      else $error("interrupt not raised");
endmodule

/* dv/gpr_lp_model.sv */
// partner model: datapath and link side feeding levels and error events
`timescale 1ns/10ps
module gpr_lp_model
   import gpr_pkg::*;
(
   // clock, reset and bench control
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic [8:0] lvl_i,
   input wire logic [15:0] evt_i,
   // status toward the register block
   output logic [8:0] lvl_o,
   output logic [15:0] evt_o
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lvl_o <= '0;
         evt_o <= '0;
      end
      else begin
         lvl_o <= lvl_i;
         // an error on the wire lasts one cycle per cycle of go
         evt_o <= go_i ? evt_i : '0;
      end
   end
endmodule

/* dv/gpr_regs_tb_top.sv */
// self-checking bench for the gigabit phy management registers
`timescale 1ns/10ps
module gpr_regs_tb_top;
   import gpr_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, ack, irq;
   logic [7:0] adr = '0;
   wire [7:0] ctl;
   logic [1:0] strap = 2'b10;
   logic [31:0] wdat = '0;
   logic [31:0] rdat;
   logic [8:0] lv = 9'h100;
   logic [8:0] lvo;
   logic [15:0] ev = '0;
   logic [15:0] evo;
   logic [31:0] seed = 32'hb4ea;
   int err_count = 0;
   int checked = 0;

   gpr_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(4'h3), .dat_i(wdat), .dat_o(rdat),
      .ack_o(ack), .config_pin_default_fdx_i(strap[1]),
      .config_pin_default_hdx_i(strap[0]), .ms_fault_i(evo[15]),
      .ms_master_i(lvo[8]), .local_rx_ok_i(lvo[7]),
      .remote_rx_ok_i(lvo[6]), .lp_fdx_i(lvo[5]), .lp_hdx_i(lvo[4]),
      .idle_err_i(evo[14]), .fe_lvl_i(gpr_lvl_s'(lvo[3:2])),
      .fe_evt_i(gpr_evt_s'(evo[13:7])), .ge_lvl_i(gpr_lvl_s'(lvo[1:0])),
      .ge_evt_i(gpr_evt_s'(evo[6:0])), .test_mode_o(ctl[7:5]),
      .ms_manual_o(ctl[4]), .ms_force_master_o(ctl[3]),
      .multi_port_o(ctl[2]), .adv_fdx_o(ctl[1]), .adv_hdx_o(ctl[0]),
      .irq_o(irq));
   gpr_lp_model LP (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .lvl_i(lv),
      .evt_i(ev), .lvl_o(lvo), .evt_o(evo));

   initial begin
      forever #4 clk_i = ~clk_i;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // c selects the value after a read has cleared the flags
   function automatic logic [15:0] expv(input logic [7:0] a, input logic c,
                                        input logic [7:0] n);
      logic [15:0] e;
      e = c ? 16'h0 : ev;
      case (a)
         GPR_IDX_GSTAT: return {e[15], lv[8:4], 2'b00, c ? 8'h00 : n};
         GPR_IDX_FEXT: return {lv[3], e[13:12], lv[2], e[11:8], 8'h00};
         GPR_IDX_GEXT: return {lv[1], e[6:5], lv[0], e[4:0], 7'h00};
         default: return 16'h0;
      endcase
   endfunction

   task automatic test_done;
      $display("checked=%0d err_count=%0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("[ PASS ]");
      end
      else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [15:0] d, output logic [15:0] r);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {16'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         err_count++;
         test_done;
      end
      r = rdat[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] r;
      wb(1'b0, a, 16'h0, r);
      chk(r, e);
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [15:0] r;
      wb(1'b1, a, d, r);
   endtask

   // hold go for n cycles, then let the event reach the registers and irq
   task automatic fire(input int n);
      @(posedge clk_i);
      go <= 1'b1;
      repeat (n) @(posedge clk_i);
      go <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      test_done;
   end

   initial begin
      logic [15:0] v;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rd(GPR_IDX_GCTRL, 16'h0600);
      chk({8'h0, ctl}, 16'h0006);
      rd(GPR_IDX_GSTAT, 16'h4000);
      rd(GPR_IDX_FEXT, 16'h0000);
      rd(GPR_IDX_GEXT, 16'h0000);
      rd(8'h30, 16'h0000);
      wr(GPR_IDX_FCAP, 16'hffff);
      rd(GPR_IDX_FCAP, 16'h3000);
      for (int i = 0; i < 10; i++) begin
         v = 16'(xs());
         v[15:13] = 3'(i % 5); // media sensing assumed off
         if (i == 5) v[12:11] = 2'b01;
         wr(GPR_IDX_GCTRL, v);
         rd(GPR_IDX_GCTRL, v);
         chk({8'h0, ctl}, {8'h0, v[15:12], v[12] & v[11], v[10:8]});
      end
      for (int i = 0; i < 12; i++) begin
         lv <= 9'(xs());
         ev <= (i == 0) ? 16'hffff : 16'(xs());
         fire(1);
         for (int c = 0; c < 2; c++) begin
            rd(GPR_IDX_GSTAT, expv(GPR_IDX_GSTAT, c[0], {7'h0, ev[14]}));
            rd(GPR_IDX_FEXT, expv(GPR_IDX_FEXT, c[0], 8'h0));
            rd(GPR_IDX_GEXT, expv(GPR_IDX_GEXT, c[0], 8'h0));
         end
         chk({15'h0, irq}, 16'h0000);
      end
      lv <= 9'h100;
      ev <= 16'h4000;
      fire(37);
      rd(GPR_IDX_GSTAT, 16'h4025);
      fire(300);
      rd(GPR_IDX_GSTAT, 16'h40ff);
      rd(GPR_IDX_GSTAT, 16'h4000);
      wb(1'b0, GPR_IDX_IRQ_STAT, 16'h0, v);
      ev <= 16'h0040;
      fire(1);
      chk({15'h0, irq}, 16'h0000);
      rd(GPR_IDX_IRQ_STAT, 16'h0004);
      wr(GPR_IDX_IRQ_MASK, 16'h000f);
      rd(GPR_IDX_IRQ_MASK, 16'h000f);
      ev <= 16'h8000;
      fire(1);
      chk({15'h0, irq}, 16'h0001);
      rd(GPR_IDX_IRQ_STAT, 16'h0001);
      repeat (2) @(posedge clk_i);
      chk({15'h0, irq}, 16'h0000);
      // mid-run reset with the other strap setting
      strap <= 2'b01;
      rst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rd(GPR_IDX_GCTRL, 16'h0500);
      chk({8'h0, ctl}, 16'h0005);
      rd(GPR_IDX_GSTAT, 16'h4000);
      chk({15'h0, irq}, 16'h0000);
      test_done;
   end
endmodule
